// ===== bench/mtsd_host_model.sv
// host side model: register word transfers and the stream slave pins
`timescale 1ns/100ps
module mtsd_host_model (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  output logic                      o_valid,
  output logic                      o_write,
  output mtsd_pkg::mtsd_addr_t      o_addr,
  output mtsd_pkg::mtsd_word_t      o_wdata,
  input  wire mtsd_pkg::mtsd_word_t i_rdata,
  input  wire logic                 i_in_oe,
  input  wire logic                 i_in_drv,
  input  wire logic                 i_out_oe,
  input  wire logic                 i_out_drv,
  output logic                      o_in_lvl,
  output logic                      o_out_lvl
);
  import mtsd_pkg::*;
  logic last_in_ff;
  logic last_out_ff;
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_addr = '0;
    o_wdata = '0;
  end
  // a released pin drifts to the inverse of its last driven level, never a stale one
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      last_in_ff  <= 1'b0;
      last_out_ff <= 1'b0;
    end else begin
      if (i_in_oe) last_in_ff <= i_in_drv;
      if (i_out_oe) last_out_ff <= i_out_drv;
    end
  end
  assign o_in_lvl = i_in_oe ? i_in_drv : ~last_in_ff;
  assign o_out_lvl = i_out_oe ? i_out_drv : ~last_out_ff;
  // called at an edge; answer is stable at the second edge
  task automatic xfer(input logic w, input mtsd_addr_t a, input mtsd_word_t d,
                      output mtsd_word_t q);
    o_valid <= 1'b1;
    o_write <= w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk_sys);
    o_valid <= 1'b0;
    @(posedge i_clk_sys);
    q = i_rdata;
  endtask : xfer
endmodule : mtsd_host_model

// ===== bench/mtsd_regs_properties.sv
// port-level checker of the threshold/stream/detector bank
`timescale 1ns/100ps
module mtsd_regs_properties (
  input wire logic                 i_clk_sys,
  input wire logic                 i_rst,
  input wire logic                 i_acc_valid,
  input wire logic                 i_acc_write,
  input wire mtsd_pkg::mtsd_addr_t i_acc_addr,
  input wire mtsd_pkg::mtsd_word_t i_acc_wdata,
  input wire mtsd_pkg::mtsd_word_t o_acc_rdata,
  input wire logic                 o_acc_hit,
  input wire logic                 i_thdn_valid,
  input wire logic                 i_volt_warn_en,
  input wire logic                 i_curr_warn_en,
  input wire mtsd_pkg::mtsd_word_t o_system_status_word_one,
  input wire logic                 i_outer_channel_swap,
  input wire logic [1:0]           o_phase_a_current_ch,
  input wire logic                 i_stream_master,
  input wire logic                 o_stream_sclk,
  input wire logic                 o_serial_in_pin_oe,
  input wire logic                 o_serial_out_pin_oe
);
  logic in_bank;
  assign in_bank = i_acc_addr >= 7'h0C && i_acc_addr <= 7'h13;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  a_volt_flag_off: assert property (
    i_thdn_valid && !i_volt_warn_en |=> !o_system_status_word_one[11])
    else $error("voltage flag set while disabled");
  a_curr_flag_off: assert property (
    i_thdn_valid && !i_curr_warn_en |=> !o_system_status_word_one[10])
    else $error("current flag set while disabled");
  a_unmapped_zero: assert property (
    i_acc_valid && !in_bank |=> !o_acc_hit && o_acc_rdata == 16'h0000)
    else $error("unmapped access answered");
  a_log_last_write: assert property (
    i_acc_valid && i_acc_write && in_bank ##1 !i_acc_valid
    ##1 i_acc_valid && !i_acc_write && i_acc_addr == 7'h0F
    |=> o_acc_rdata == $past(i_acc_wdata, 3))
    else $error("log does not hold last write");
  a_trip_reserved: assert property (
    i_acc_valid && !i_acc_write && in_bank && i_acc_addr > 7'h10
    |=> (o_acc_rdata & 16'h8080) == 16'h0000)
    else $error("trip reserved bits read nonzero");
  a_swap_map: assert property (
    1'b1 |=> o_phase_a_current_ch == ($past(i_outer_channel_swap) ? 2'h3 : 2'h1))
    else $error("phase A channel map wrong");
  a_sclk_idle_hold: assert property (
    (!i_stream_master && !i_acc_valid) [*3] |=> $stable(o_stream_sclk))
    else $error("serial clock moves while idle");
  a_pin_roles: assert property (
    i_stream_master [*2] |-> o_serial_in_pin_oe != o_serial_out_pin_oe)
    else $error("serial pin roles not exclusive");
  c_hit: cover property (o_acc_hit);
  c_sclk: cover property ($rose(o_stream_sclk));
  c_flag: cover property (o_system_status_word_one[10]);
endmodule : mtsd_regs_properties

bind mtsd_regs mtsd_regs_properties u_props (
  .i_clk_sys, .i_rst, .i_acc_valid, .i_acc_write, .i_acc_addr, .i_acc_wdata,
  .o_acc_rdata, .o_acc_hit, .i_thdn_valid, .i_volt_warn_en, .i_curr_warn_en,
  .o_system_status_word_one, .i_outer_channel_swap, .o_phase_a_current_ch,
  .i_stream_master, .o_stream_sclk, .o_serial_in_pin_oe, .o_serial_out_pin_oe
);

// ===== bench/mtsd_regs_tb.sv
// self-checking bench of the threshold/stream/detector register bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module mtsd_regs_tb;
  import mtsd_pkg::*;
  logic i_clk_sys, i_rst, i_acc_valid, i_acc_write, i_thdn_valid, i_volt_warn_en;
  logic i_curr_warn_en, i_outer_channel_swap, i_stream_master, i_stream_mosi;
  logic i_slave_out_en, i_slave_out_data, i_serial_in_pin, i_serial_out_pin, o_acc_hit;
  logic o_stream_sclk, o_stream_launch, o_stream_capture, o_serial_in_pin, o_stream_miso;
  logic o_serial_in_pin_oe, o_serial_out_pin, o_serial_out_pin_oe;
  mtsd_addr_t i_acc_addr;
  mtsd_word_t i_acc_wdata, i_ext_rdata, o_acc_rdata, i_volt_thdn, i_curr_thdn;
  mtsd_word_t o_system_status_word_one;
  logic [1:0] o_phase_a_current_ch, o_phase_c_current_ch;
  logic [6:0] o_stream_channel_select;
  logic [5:0] o_sample_word_width, o_detector_power_down;
  logic [2:0][6:0] o_negative_trip_code, o_positive_trip_code;
  int n_mismatch = 0;
  int total_checks = 0;
  mtsd_regs i_dut (
    .i_clk_sys, .i_rst, .i_acc_valid, .i_acc_write, .i_acc_addr, .i_acc_wdata, .i_ext_rdata,
    .o_acc_rdata, .o_acc_hit, .i_thdn_valid, .i_volt_thdn, .i_curr_thdn, .i_volt_warn_en,
    .i_curr_warn_en, .o_system_status_word_one, .i_outer_channel_swap, .o_phase_a_current_ch,
    .o_phase_c_current_ch, .i_stream_master, .o_stream_channel_select, .o_sample_word_width,
    .o_stream_sclk, .o_stream_launch, .o_stream_capture, .i_stream_mosi, .o_stream_miso,
    .i_slave_out_en, .i_slave_out_data, .i_serial_in_pin, .o_serial_in_pin,
    .o_serial_in_pin_oe, .i_serial_out_pin, .o_serial_out_pin, .o_serial_out_pin_oe,
    .o_detector_power_down, .o_negative_trip_code, .o_positive_trip_code
  );
  mtsd_host_model i_host (
    .i_clk_sys, .i_rst, .o_valid(i_acc_valid), .o_write(i_acc_write), .o_addr(i_acc_addr),
    .o_wdata(i_acc_wdata), .i_rdata(o_acc_rdata), .i_in_oe(o_serial_in_pin_oe),
    .i_in_drv(o_serial_in_pin), .i_out_oe(o_serial_out_pin_oe), .i_out_drv(o_serial_out_pin),
    .o_in_lvl(i_serial_in_pin), .o_out_lvl(i_serial_out_pin)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : tick
  task automatic guard(input int n);
    if (n >= 60) begin
      n_mismatch++;
      final_report;
    end
  endtask : guard
  task automatic rd(input mtsd_addr_t a, input mtsd_word_t e);
    mtsd_word_t q;
    logic       h;
    h = (a >= 7'h0C) && (a <= 7'h13);
    i_host.xfer(1'b0, a, 16'h0000, q);
    `CHK("rdata", e, q)
    `CHK("hit", h, o_acc_hit)
  endtask : rd
  task automatic wr(input mtsd_addr_t a, input mtsd_word_t d);
    mtsd_word_t q;
    i_host.xfer(1'b1, a, d, q);
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    rd(7'h0F, 16'h0000);
    rd(7'h0C, 16'hFFFF);
    rd(7'h0D, 16'hFFFF);
    rd(7'h0E, 16'h7E44);
    rd(7'h0F, 16'h7E44);
    `CHK("width", 6'h18, o_sample_word_width)
    `CHK("chsel", 7'h3F, o_stream_channel_select)
  endtask : t_reset_vals
  task automatic t_detect;
    wr(7'h10, 16'hFFFF);
    `CHK("pd", 6'h3F, o_detector_power_down)
    wr(7'h11, 16'hB2C5);
    `CHK("neg1", 7'h32, o_negative_trip_code[0])
    `CHK("pos1", 7'h45, o_positive_trip_code[0])
    wr(7'h12, 16'hFFFF);
    `CHK("neg2", 7'h7F, o_negative_trip_code[1])
    `CHK("pos2", 7'h7F, o_positive_trip_code[1])
    wr(7'h13, 16'h8001);
    `CHK("pos3", 7'h01, o_positive_trip_code[2])
    rd(7'h10, 16'h003F);
    rd(7'h12, 16'h7F7F);
    i_rst <= 1'b1;
    tick(1);
    i_rst <= 1'b0;
    `CHK("pd", 6'h3F, o_detector_power_down)
    `CHK("neg1", 7'h32, o_negative_trip_code[0])
    rd(7'h11, 16'h0000);
    // only the control word is written; channel 1 must reload from its cleared copy
    wr(7'h10, 16'h0005);
    `CHK("pd", 6'h05, o_detector_power_down)
    `CHK("neg1", 7'h00, o_negative_trip_code[0])
  endtask : t_detect
  task automatic t_log;
    wr(7'h0C, 16'h1357);
    rd(7'h0F, 16'h1357);
    i_ext_rdata <= 16'hABCD;
    rd(7'h40, 16'h0000);
    rd(7'h0F, 16'hABCD);
  endtask : t_log
  task automatic ck_thdn(input mtsd_word_t v, c, input logic ve, ce, input mtsd_word_t e);
    i_volt_thdn <= v;
    i_curr_thdn <= c;
    i_volt_warn_en <= ve;
    i_curr_warn_en <= ce;
    i_thdn_valid <= 1'b1;
    tick(1);
    i_thdn_valid <= 1'b0;
    tick(1);
    `CHK("status", e, o_system_status_word_one)
  endtask : ck_thdn
  task automatic t_thdn;
    wr(7'h0D, 16'h0200);
    ck_thdn(16'h1357, 16'h0201, 1'b1, 1'b1, 16'h0400);
    ck_thdn(16'h1358, 16'h0200, 1'b1, 1'b1, 16'h0800);
    ck_thdn(16'hFFFF, 16'hFFFF, 1'b0, 1'b1, 16'h0400);
    ck_thdn(16'hFFFF, 16'hFFFF, 1'b1, 1'b0, 16'h0800);
  endtask : t_thdn
  task automatic t_swap;
    i_outer_channel_swap <= 1'b1;
    tick(2);
    `CHK("ph_a", 2'h3, o_phase_a_current_ch)
    `CHK("ph_c", 2'h1, o_phase_c_current_ch)
    i_outer_channel_swap <= 1'b0;
    tick(2);
    `CHK("ph_a", 2'h1, o_phase_a_current_ch)
  endtask : t_swap
  task automatic run_clk(input logic idle, first, dir, miso);
    int n;
    logic s;
    wr(7'h0E, {7'h7F, dir, 2'b01, idle, first, 4'h3});
    tick(1);
    `CHK("sclk_idle", idle, o_stream_sclk)
    i_stream_master <= 1'b1;
    i_stream_mosi <= 1'b1;
    n = 0;
    while (!(o_stream_launch === 1'b1 || o_stream_capture === 1'b1) && n < 60) begin
      tick(1);
      n++;
    end
    guard(n);
    `CHK("first_launch", first, o_stream_launch)
    `CHK("first_capture", ~first, o_stream_capture)
    for (int j = 0; j < 2; j++) begin
      s = o_stream_sclk;
      n = 0;
      while (o_stream_sclk === s && n < 60) begin
        tick(1);
        n++;
      end
      guard(n);
    end
    `CHK("half_period", 3, n)
    `CHK("in_oe", ~dir, o_serial_in_pin_oe)
    `CHK("out_oe", dir, o_serial_out_pin_oe)
    `CHK("mosi_pin", 1'b1, dir ? o_serial_out_pin : o_serial_in_pin)
    `CHK("miso", miso, o_stream_miso)
    i_stream_master <= 1'b0;
    i_stream_mosi <= 1'b0;
    tick(2);
    `CHK("sclk_idle", idle, o_stream_sclk)
  endtask : run_clk
  task automatic t_stream;
    logic [5:0] wtab [4];
    wtab = '{6'h20, 6'h18, 6'h10, 6'h18};
    for (int k = 0; k < 4; k++) begin
      wr(7'h0E, {7'h55, 1'b0, 2'(k), 6'h02});
      tick(1);
      `CHK("width", wtab[k], o_sample_word_width)
    end
    `CHK("chsel", 7'h55, o_stream_channel_select)
    run_clk(1'b1, 1'b1, 1'b0, 1'b1);
    run_clk(1'b0, 1'b0, 1'b1, 1'b0);
  endtask : t_stream
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    i_rst = 1'b1;
    i_thdn_valid = 1'b0;
    i_volt_thdn = 16'h0000;
    i_curr_thdn = 16'h0000;
    i_volt_warn_en = 1'b0;
    i_curr_warn_en = 1'b0;
    i_outer_channel_swap = 1'b0;
    i_stream_master = 1'b0;
    i_stream_mosi = 1'b0;
    i_slave_out_en = 1'b0;
    i_slave_out_data = 1'b0;
    i_ext_rdata = 16'h0000;
    tick(3);
    i_rst <= 1'b0;
    t_reset_vals;
    t_detect;
    t_log;
    t_thdn;
    t_swap;
    t_stream;
    final_report;
  end
endmodule : mtsd_regs_tb

// ===== hdl/mtsd_defs.svh
// offsets, field positions and reset values of the threshold/stream/detector bank
`ifndef MTSD_DEFS_SVH
`define MTSD_DEFS_SVH

`define MTSD_ADDR_W           7
`define MTSD_DATA_W           16

`define MTSD_OFF_VOLT_LIMIT   7'h0C
`define MTSD_OFF_CURR_LIMIT   7'h0D
`define MTSD_OFF_STREAM_CTRL  7'h0E
`define MTSD_OFF_XFER_LOG     7'h0F
`define MTSD_OFF_DET_PD       7'h10
`define MTSD_OFF_DET_TRIP1    7'h11
`define MTSD_OFF_DET_TRIP2    7'h12
`define MTSD_OFF_DET_TRIP3    7'h13

`define MTSD_RST_VOLT_LIMIT   16'hFFFF
`define MTSD_RST_CURR_LIMIT   16'hFFFF
`define MTSD_RST_STREAM_CTRL  16'h7E44
`define MTSD_RST_XFER_LOG     16'h0000
`define MTSD_RST_DET_PD       16'h0000
`define MTSD_RST_DET_TRIP     16'h0000

`define MTSD_STAT_VOLT_BIT    11
`define MTSD_STAT_CURR_BIT    10
`define MTSD_SWAP_BIT         13

`define MTSD_SC_CHSEL_HI      15
`define MTSD_SC_CHSEL_LO      9
`define MTSD_SC_PIN_DIR       8
`define MTSD_SC_WIDTH_HI      7
`define MTSD_SC_WIDTH_LO      6
`define MTSD_SC_CLK_IDLE      5
`define MTSD_SC_LAUNCH        4
`define MTSD_SC_DIV_HI        3
`define MTSD_SC_DIV_LO        0

`define MTSD_DET_PD_MASK      16'h003F
`define MTSD_TRIP_MASK        16'h7F7F
`define MTSD_TRIP_NEG_HI      14
`define MTSD_TRIP_NEG_LO      8
`define MTSD_TRIP_POS_HI      6
`define MTSD_TRIP_POS_LO      0

`define MTSD_BITS_32          6'h20
`define MTSD_BITS_24          6'h18
`define MTSD_BITS_16          6'h10

`endif

// ===== hdl/mtsd_pkg.sv
// types shared by the threshold/stream/detector bank
package mtsd_pkg;
  typedef logic [15:0] mtsd_word_t;
  typedef logic [6:0]  mtsd_addr_t;
  typedef logic [6:0]  mtsd_trip_t;
  typedef enum logic [1:0] {
    MTSD_W32,
    MTSD_W24,
    MTSD_W16,
    MTSD_WRSV
  } mtsd_width_e;
endpackage : mtsd_pkg

// ===== hdl/mtsd_regs.sv
// threshold, sample stream control, transfer log and detector register bank
`timescale 1ns/100ps
`include "mtsd_defs.svh"

module mtsd_regs (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic              i_acc_valid,
  input  wire logic              i_acc_write,
  input  wire mtsd_pkg::mtsd_addr_t i_acc_addr,
  input  wire mtsd_pkg::mtsd_word_t i_acc_wdata,
  input  wire mtsd_pkg::mtsd_word_t i_ext_rdata,
  output mtsd_pkg::mtsd_word_t   o_acc_rdata,
  output logic                   o_acc_hit,
  input  wire logic              i_thdn_valid,
  input  wire mtsd_pkg::mtsd_word_t i_volt_thdn,
  input  wire mtsd_pkg::mtsd_word_t i_curr_thdn,
  input  wire logic              i_volt_warn_en,
  input  wire logic              i_curr_warn_en,
  output mtsd_pkg::mtsd_word_t   o_system_status_word_one,
  input  wire logic              i_outer_channel_swap,
  output logic [1:0]             o_phase_a_current_ch,
  output logic [1:0]             o_phase_c_current_ch,
  input  wire logic              i_stream_master,
  output logic [6:0]             o_stream_channel_select,
  output logic [5:0]             o_sample_word_width,
  output logic                   o_stream_sclk,
  output logic                   o_stream_launch,
  output logic                   o_stream_capture,
  input  wire logic              i_stream_mosi,
  output logic                   o_stream_miso,
  input  wire logic              i_slave_out_en,
  input  wire logic              i_slave_out_data,
  input  wire logic              i_serial_in_pin,
  output logic                   o_serial_in_pin,
  output logic                   o_serial_in_pin_oe,
  input  wire logic              i_serial_out_pin,
  output logic                   o_serial_out_pin,
  output logic                   o_serial_out_pin_oe,
  output logic [5:0]             o_detector_power_down,
  output logic [2:0][6:0]        o_negative_trip_code,
  output logic [2:0][6:0]        o_positive_trip_code
);
  import mtsd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // software visible registers

  mtsd_word_t  volt_limit_ff;
  mtsd_word_t  curr_limit_ff;
  mtsd_word_t  stream_ctrl_ff;
  mtsd_word_t  xfer_log_ff;
  mtsd_word_t  det_pd_ff;
  mtsd_word_t  det_trip_ff [3];
  mtsd_word_t  nxt_det_pd;
  mtsd_word_t  nxt_det_trip [3];
  mtsd_word_t  rd_mux;
  logic        rd_hit;
  logic        wr_en;
  logic        det_wr;
  logic        volt_over_ff;
  logic        curr_over_ff;
  mtsd_width_e width_sel;

  assign wr_en  = i_acc_valid && i_acc_write;
  assign det_wr = wr_en && (i_acc_addr >= `MTSD_OFF_DET_PD)
                        && (i_acc_addr <= `MTSD_OFF_DET_TRIP3);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      volt_limit_ff <= `MTSD_RST_VOLT_LIMIT;
    end else if (wr_en && (i_acc_addr == `MTSD_OFF_VOLT_LIMIT)) begin
      volt_limit_ff <= i_acc_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      curr_limit_ff <= `MTSD_RST_CURR_LIMIT;
    end else if (wr_en && (i_acc_addr == `MTSD_OFF_CURR_LIMIT)) begin
      curr_limit_ff <= i_acc_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      stream_ctrl_ff <= `MTSD_RST_STREAM_CTRL;
    end else if (wr_en && (i_acc_addr == `MTSD_OFF_STREAM_CTRL)) begin
      stream_ctrl_ff <= i_acc_wdata;
    end
  end

  // the register copies take the new word in the same edge as the latches
  always_comb begin
    nxt_det_pd = det_pd_ff;
    for (int k = 0; k < 3; k++) begin
      nxt_det_trip[k] = det_trip_ff[k];
    end
    if (wr_en) begin
      case (i_acc_addr)
        `MTSD_OFF_DET_PD:    nxt_det_pd      = i_acc_wdata & `MTSD_DET_PD_MASK;
        `MTSD_OFF_DET_TRIP1: nxt_det_trip[0] = i_acc_wdata & `MTSD_TRIP_MASK;
        `MTSD_OFF_DET_TRIP2: nxt_det_trip[1] = i_acc_wdata & `MTSD_TRIP_MASK;
        `MTSD_OFF_DET_TRIP3: nxt_det_trip[2] = i_acc_wdata & `MTSD_TRIP_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      det_pd_ff <= `MTSD_RST_DET_PD;
      for (int k = 0; k < 3; k++) begin
        det_trip_ff[k] <= `MTSD_RST_DET_TRIP;
      end
    end else begin
      det_pd_ff <= nxt_det_pd;
      for (int k = 0; k < 3; k++) begin
        det_trip_ff[k] <= nxt_det_trip[k];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path and transfer log

  always_comb begin
    rd_hit = 1'b1;
    case (i_acc_addr)
      `MTSD_OFF_VOLT_LIMIT:  rd_mux = volt_limit_ff;
      `MTSD_OFF_CURR_LIMIT:  rd_mux = curr_limit_ff;
      `MTSD_OFF_STREAM_CTRL: rd_mux = stream_ctrl_ff;
      `MTSD_OFF_XFER_LOG:    rd_mux = xfer_log_ff;
      `MTSD_OFF_DET_PD:      rd_mux = det_pd_ff;
      `MTSD_OFF_DET_TRIP1:   rd_mux = det_trip_ff[0];
      `MTSD_OFF_DET_TRIP2:   rd_mux = det_trip_ff[1];
      `MTSD_OFF_DET_TRIP3:   rd_mux = det_trip_ff[2];
      default: begin
        rd_mux = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_acc_rdata <= 16'h0000;
      o_acc_hit   <= 1'b0;
    end else if (i_acc_valid) begin
      o_acc_rdata <= i_acc_write ? 16'h0000 : rd_mux;
      o_acc_hit   <= rd_hit;
    end else begin
      o_acc_hit   <= 1'b0;
    end
  end

  // every transfer is logged, also those that land in other banks, so a
  // read of a clear-on-read register elsewhere can still be checked
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      xfer_log_ff <= `MTSD_RST_XFER_LOG;
    end else if (i_acc_valid) begin
      if (i_acc_write) begin
        xfer_log_ff <= i_acc_wdata;
      end else begin
        xfer_log_ff <= rd_hit ? rd_mux : i_ext_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // detector configuration latches

  // no reset on purpose: contents survive digital reset and every power
  // mode; until the host programs one of the four registers they are unknown
  always_ff @(posedge i_clk_sys) begin
    if (det_wr) begin
      o_detector_power_down <= nxt_det_pd[5:0];
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_trip
    always_ff @(posedge i_clk_sys) begin
      if (det_wr) begin
        // codes pass straight to the detector dac, linear in the code
        o_negative_trip_code[g] <=
          nxt_det_trip[g][`MTSD_TRIP_NEG_HI:`MTSD_TRIP_NEG_LO];
        o_positive_trip_code[g] <=
          nxt_det_trip[g][`MTSD_TRIP_POS_HI:`MTSD_TRIP_POS_LO];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // distortion warnings

  // the flags follow each new result, so a result back under the limit clears
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      volt_over_ff <= 1'b0;
    end else if (i_thdn_valid) begin
      volt_over_ff <= i_volt_warn_en && (i_volt_thdn > volt_limit_ff);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      curr_over_ff <= 1'b0;
    end else if (i_thdn_valid) begin
      curr_over_ff <= i_curr_warn_en && (i_curr_thdn > curr_limit_ff);
    end
  end

  always_comb begin
    o_system_status_word_one                      = 16'h0000;
    o_system_status_word_one[`MTSD_STAT_VOLT_BIT] = volt_over_ff;
    o_system_status_word_one[`MTSD_STAT_CURR_BIT] = curr_over_ff;
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel mapping and stream configuration

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_phase_a_current_ch <= 2'h1;
      o_phase_c_current_ch <= 2'h3;
    end else begin
      o_phase_a_current_ch <= i_outer_channel_swap ? 2'h3 : 2'h1;
      o_phase_c_current_ch <= i_outer_channel_swap ? 2'h1 : 2'h3;
    end
  end

  assign width_sel = mtsd_width_e'(stream_ctrl_ff[`MTSD_SC_WIDTH_HI:`MTSD_SC_WIDTH_LO]);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_stream_channel_select <= 7'h00;
    end else begin
      o_stream_channel_select <=
        stream_ctrl_ff[`MTSD_SC_CHSEL_HI:`MTSD_SC_CHSEL_LO];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sample_word_width <= `MTSD_BITS_24;
    end else begin
      case (width_sel)
        MTSD_W32: o_sample_word_width <= `MTSD_BITS_32;
        MTSD_W16: o_sample_word_width <= `MTSD_BITS_16;
        // the reserved code falls back to the default width
        default:  o_sample_word_width <= `MTSD_BITS_24;
      endcase
    end
  end

  mtsd_sclk_gen #(
    .DIV_W (4)
  ) u_sclk (
    .i_clk_sys    (i_clk_sys),
    .i_rst        (i_rst),
    .i_run        (i_stream_master),
    .i_div        (stream_ctrl_ff[`MTSD_SC_DIV_HI:`MTSD_SC_DIV_LO]),
    .i_idle_high  (stream_ctrl_ff[`MTSD_SC_CLK_IDLE]),
    .i_first_edge (stream_ctrl_ff[`MTSD_SC_LAUNCH]),
    .o_sclk       (o_stream_sclk),
    .o_launch     (o_stream_launch),
    .o_capture    (o_stream_capture)
  );

  //////////////////////////////////////////////////////////////////////////////
  // serial pin roles

  logic pin_rev;
  logic in_meta_ff;
  logic in_sync_ff;
  logic out_meta_ff;
  logic out_sync_ff;

  assign pin_rev = stream_ctrl_ff[`MTSD_SC_PIN_DIR];

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      in_meta_ff  <= 1'b0;
      in_sync_ff  <= 1'b0;
      out_meta_ff <= 1'b0;
      out_sync_ff <= 1'b0;
    end else begin
      in_meta_ff  <= i_serial_in_pin;
      in_sync_ff  <= in_meta_ff;
      out_meta_ff <= i_serial_out_pin;
      out_sync_ff <= out_meta_ff;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_serial_in_pin    <= 1'b0;
      o_serial_in_pin_oe <= 1'b0;
    end else if (i_stream_master) begin
      o_serial_in_pin    <= i_stream_mosi;
      o_serial_in_pin_oe <= !pin_rev;
    end else begin
      o_serial_in_pin    <= 1'b0;
      o_serial_in_pin_oe <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_serial_out_pin    <= 1'b0;
      o_serial_out_pin_oe <= 1'b0;
    end else if (i_stream_master) begin
      o_serial_out_pin    <= i_stream_mosi;
      o_serial_out_pin_oe <= pin_rev;
    end else begin
      // as a plain slave only the serial-out pin is ever driven
      o_serial_out_pin    <= i_slave_out_data;
      o_serial_out_pin_oe <= i_slave_out_en;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_stream_miso <= 1'b0;
    end else if (i_stream_master) begin
      o_stream_miso <= pin_rev ? in_sync_ff : out_sync_ff;
    end else begin
      o_stream_miso <= 1'b0;
    end
  end
endmodule : mtsd_regs

// ===== hdl/mtsd_sclk_gen.sv
// streaming serial clock divider with idle level and launch edge choice
`timescale 1ns/100ps
module mtsd_sclk_gen #(
  parameter int DIV_W = 4
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_run,
  input  wire logic [DIV_W-1:0] i_div,
  input  wire logic             i_idle_high,
  input  wire logic             i_first_edge,
  output logic                  o_sclk,
  output logic                  o_launch,
  output logic                  o_capture
);
  logic [DIV_W-1:0] cnt_ff;
  logic             second_ff;
  logic [DIV_W-1:0] half_len;
  logic             edge_now;
  logic             is_launch;

  // a ratio of zero would stop the clock, so it behaves as one
  assign half_len  = (i_div == '0) ? DIV_W'(1) : i_div;
  assign edge_now  = i_run && (cnt_ff >= half_len - DIV_W'(1));
  assign is_launch = i_first_edge ? !second_ff : second_ff;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
    end else if (!i_run || edge_now) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sclk    <= 1'b0;
      second_ff <= 1'b0;
    end else if (!i_run) begin
      o_sclk    <= i_idle_high;
      second_ff <= 1'b0;
    end else if (edge_now) begin
      o_sclk    <= !o_sclk;
      second_ff <= !second_ff;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_launch  <= 1'b0;
      o_capture <= 1'b0;
    end else begin
      o_launch  <= edge_now && is_launch;
      o_capture <= edge_now && !is_launch;
    end
  end
endmodule : mtsd_sclk_gen
